/* File: logic/auxio_map.vh */
// Operation
// - the set-settings frame is tagged 0x6f696573 and is 18 bytes long.
// - the frame holds code, config flags, behaviour, 10 spare, checksum.
// - an accepted set-settings frame is answered by its code alone.
// - get-settings is the bare code 0x6f696567, answered by 18 bytes.
// - config bit 0x01 makes the pin an output, else it is an input.
// - config bit 0x02 inverts the pin: falling edge, low is active.
// - without inversion a rising edge is the event, high is active.
// - the low behaviour nibble picks the action on an input event.
// - actions 0 none, 1 halt, 2 windings off, 3 relative move, 4 home.
// - action 5 raises the alarm when the input becomes active.
// - the high nibble picks the output; 0x00 off, 0x10 always on.
// - output 0x20 follows motion, 0x30 follows the alarm condition.
// - output 0x40 follows winding power, 0x50 follows motor presence.
// - set-settings stores its values and get-settings returns them; the 10 spare bytes come back as 0x00.
`ifndef AUXIO_MAP_VH
`define AUXIO_MAP_VH

// ----------------------------------------
// frame codes and layout
// ----------------------------------------
`define AUXIO_CMD_SET      32'h6f696573
`define AUXIO_CMD_GET      32'h6f696567
`define AUXIO_FRAME_LEN    5'h12
`define AUXIO_CODE_LEN     5'h04
`define AUXIO_POS_FLAGS    5'h04
`define AUXIO_POS_BEHAV    5'h05
`define AUXIO_POS_CRC_LO   5'h10
`define AUXIO_POS_CRC_HI   5'h11

// ----------------------------------------
// setting fields
// ----------------------------------------
`define AUXIO_FLAG_OUTPUT  0
`define AUXIO_FLAG_INVERT  1
`define AUXIO_IN_MASK      8'h0f
`define AUXIO_OUT_MASK     8'hf0
`define AUXIO_IN_NOP       8'h00
`define AUXIO_IN_HALT      8'h01
`define AUXIO_IN_PWOFF     8'h02
`define AUXIO_IN_MOVE      8'h03
`define AUXIO_IN_HOME      8'h04
`define AUXIO_IN_ALARM     8'h05
`define AUXIO_OUT_OFF      8'h00
`define AUXIO_OUT_ON       8'h10
`define AUXIO_OUT_MOVING   8'h20
`define AUXIO_OUT_ALARM    8'h30
`define AUXIO_OUT_POWERED  8'h40
`define AUXIO_OUT_PRESENT  8'h50
`define AUXIO_RST_FLAGS    8'h00
`define AUXIO_RST_BEHAV    8'h00

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define AUXIO_REG_REQ      8'h00
`define AUXIO_REG_RSP      8'h04
`define AUXIO_REG_FRAME    8'h08
`define AUXIO_REG_SET      8'h0c
`define AUXIO_REG_ISTAT    8'h10
`define AUXIO_REG_ICLR     8'h14
`define AUXIO_REG_IEN      8'h18
`define AUXIO_REG_PIN      8'h1c

// ----------------------------------------
// events and bus answers
// ----------------------------------------
`define AUXIO_EV_INPUT     0
`define AUXIO_EV_STORED    1
`define AUXIO_EV_ERROR     2
`define AUXIO_EV_ANSWER    3
`define AUXIO_EV_W         4
`define AUXIO_RESP_OKAY    2'b00
`define AUXIO_RESP_SLVERR  2'b10

`endif

/* File: logic/auxio_sync.v */
`default_nettype none

// ----------------------------------------
// pin synchroniser with edge detect
// ----------------------------------------
module auxio_sync (
	// clock and reset
	input  wire clk,
	input  wire rst,
	// asynchronous pin
	input  wire pin,
	// synchronous view
	output wire level,
	output wire rise,
	output wire fall
);

	reg       meta;
	reg       stable;
	reg       last;
	reg [1:0] armed;

	// chain keeps sampling through reset, so a pin resting high
	// does not look like an edge once reset lets go
	always @(posedge clk) begin
		meta   <= pin;
		stable <= meta;
		last   <= stable;
	end

	// edges stay masked until the chain holds real pin history
	always @(posedge clk) begin
		if (rst) begin
			armed <= 2'b00;
		end else begin
			armed <= {armed[0], 1'b1};
		end
	end

	assign level = stable;
	assign rise  = armed[1] & stable & ~last;
	assign fall  = armed[1] & ~stable & last;

endmodule // auxio_sync

`default_nettype wire

/* File: logic/auxio_pin.v */
`include "auxio_map.vh"
`default_nettype none

module auxio_pin (
	// clock and reset
	input  wire        clk,
	input  wire        rst,
	// axi4-lite write address
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read address
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// axi4-lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// auxiliary pin
	input  wire        aux_pin_in,
	output reg         aux_pin_out,
	output reg         aux_pin_oe,
	// motion engine state
	input  wire        motor_moving,
	input  wire        alarm_active,
	input  wire        windings_powered,
	input  wire        motor_present,
	// motion engine requests
	output reg         halt_cmd,
	output reg         windings_power_off_cmd,
	output reg         relative_move_cmd,
	output reg         home_cmd,
	output reg         alarm_set_cmd,
	// interrupt
	output reg         irq
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function hit;
		input [7:0] addr;
		input [7:0] off;
		begin
			hit = (addr[7:2] == off[7:2]);
		end
	endfunction

	function [7:0] code_byte;
		input [31:0] code;
		input [1:0]  idx;
		begin
			code_byte = code[{idx, 3'b000} +: 8];
		end
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	localparam [2:0] ST_CODE = 3'b001;
	localparam [2:0] ST_BODY = 3'b010;
	localparam [2:0] ST_RSP  = 3'b100;

	reg  [2:0]  state;
	reg  [7:0]  req_buf [0:17];
	reg  [4:0]  req_cnt;
	reg  [4:0]  rsp_idx;
	reg  [4:0]  rsp_len;
	reg  [31:0] rsp_code;
	reg  [7:0]  aux_config_flags;
	reg  [7:0]  aux_behaviour_byte;
	reg  [15:0] stored_crc;
	reg  [3:0]  irq_stat;
	reg  [3:0]  irq_en;
	reg  [7:0]  aw_addr;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	reg         aw_got;
	reg         w_got;

	wire        pin_level;
	wire        pin_rise;
	wire        pin_fall;
	wire [31:0] got_code;
	wire        do_write;
	wire        do_read;
	wire        push;
	wire        pop;
	wire        abort;
	wire [3:0]  clr;
	wire        in_active;
	wire        in_event;
	reg  [7:0]  rsp_byte;
	reg         out_active;
	reg  [3:0]  ev;
	reg  [31:0] next_rdata;
	reg  [1:0]  next_rresp;

	integer i;

	// ----------------------------------------
	// pin input
	// ----------------------------------------
	auxio_sync u_sync (
		.clk   (clk),
		.rst   (rst),
		.pin   (aux_pin_in),
		.level (pin_level),
		.rise  (pin_rise),
		.fall  (pin_fall)
	);

	// edge follows the polarity choice; only counts in input mode
	assign in_event = ~aux_config_flags[`AUXIO_FLAG_OUTPUT] &
		(aux_config_flags[`AUXIO_FLAG_INVERT] ? pin_fall
		                                      : pin_rise);
	assign in_active = pin_level ^ aux_config_flags[`AUXIO_FLAG_INVERT];

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	assign do_write = aw_got & w_got & ~s_axi_bvalid;
	assign do_read  = s_axi_arvalid & s_axi_arready;
	assign push  = do_write & w_strb[0] & hit(aw_addr, `AUXIO_REG_REQ);
	assign abort = do_write & w_strb[0] & w_data[0] &
		hit(aw_addr, `AUXIO_REG_FRAME);
	assign clr   = (do_write & w_strb[0] &
		hit(aw_addr, `AUXIO_REG_ICLR)) ? w_data[3:0] : 4'h0;
	assign pop   = do_read & hit(s_axi_araddr, `AUXIO_REG_RSP) &
		(state == ST_RSP);
	assign got_code = {s_axi_wdata_byte(w_data), req_buf[2],
		req_buf[1], req_buf[0]};

	function [7:0] s_axi_wdata_byte;
		input [31:0] d;
		begin
			s_axi_wdata_byte = d[7:0];
		end
	endfunction

	// ----------------------------------------
	// answer byte
	// ----------------------------------------
	always @* begin
		rsp_byte = 8'h00;
		if (rsp_idx < `AUXIO_CODE_LEN)
			rsp_byte = code_byte(rsp_code, rsp_idx[1:0]);
		else if (rsp_idx == `AUXIO_POS_FLAGS)
			rsp_byte = aux_config_flags;
		else if (rsp_idx == `AUXIO_POS_BEHAV)
			rsp_byte = aux_behaviour_byte;
		else if (rsp_idx == `AUXIO_POS_CRC_LO)
			rsp_byte = stored_crc[7:0];
		else if (rsp_idx == `AUXIO_POS_CRC_HI)
			rsp_byte = stored_crc[15:8];
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always @* begin
		next_rdata = 32'h0000_0000;
		next_rresp = `AUXIO_RESP_OKAY;
		if (hit(s_axi_araddr, `AUXIO_REG_RSP))
			next_rdata = {24'h00_0000,
				(state == ST_RSP) ? rsp_byte : 8'h00};
		else if (hit(s_axi_araddr, `AUXIO_REG_FRAME))
			next_rdata = {11'h000, req_cnt, 3'h0, rsp_len - rsp_idx,
				7'h00, state == ST_RSP};
		else if (hit(s_axi_araddr, `AUXIO_REG_SET))
			next_rdata = {16'h0000, aux_behaviour_byte,
				aux_config_flags};
		else if (hit(s_axi_araddr, `AUXIO_REG_ISTAT))
			next_rdata = {28'h000_0000, irq_stat};
		else if (hit(s_axi_araddr, `AUXIO_REG_IEN))
			next_rdata = {28'h000_0000, irq_en};
		else if (hit(s_axi_araddr, `AUXIO_REG_PIN))
			next_rdata = {30'h0000_0000, in_active, pin_level};
		else if (!hit(s_axi_araddr, `AUXIO_REG_REQ) &&
		         !hit(s_axi_araddr, `AUXIO_REG_ICLR))
			next_rresp = `AUXIO_RESP_SLVERR;
	end

	// ----------------------------------------
	// axi4-lite handshakes
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `AUXIO_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `AUXIO_RESP_OKAY;
			aw_got <= 1'b0;
			w_got  <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				aw_got <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_got <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_got <= 1'b0;
				w_got  <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (hit(aw_addr, `AUXIO_REG_RSP) ||
				    hit(aw_addr, `AUXIO_REG_ISTAT) ||
				    hit(aw_addr, `AUXIO_REG_SET) ||
				    hit(aw_addr, `AUXIO_REG_PIN) ||
				    aw_addr[7:2] > `AUXIO_REG_PIN >> 2)
					s_axi_bresp <= `AUXIO_RESP_SLVERR;
				else
					s_axi_bresp <= `AUXIO_RESP_OKAY;
			end
			// readies return only once the response is taken
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (do_read) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= next_rdata;
				s_axi_rresp   <= next_rresp;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// frame engine
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			state <= ST_CODE;
			req_cnt <= 5'h00;
			rsp_idx <= 5'h00;
			rsp_len <= 5'h00;
			rsp_code <= 32'h0000_0000;
			aux_config_flags <= `AUXIO_RST_FLAGS;
			aux_behaviour_byte <= `AUXIO_RST_BEHAV;
			stored_crc <= 16'h0000;
			ev[`AUXIO_EV_INPUT]  <= 1'b0;
			ev[`AUXIO_EV_STORED] <= 1'b0;
			ev[`AUXIO_EV_ERROR]  <= 1'b0;
			ev[`AUXIO_EV_ANSWER] <= 1'b0;
			for (i = 0; i < 18; i = i + 1)
				req_buf[i] <= 8'h00;
		end else begin
			ev[`AUXIO_EV_INPUT]  <= in_event;
			ev[`AUXIO_EV_STORED] <= 1'b0;
			ev[`AUXIO_EV_ERROR]  <= 1'b0;
			ev[`AUXIO_EV_ANSWER] <= 1'b0;
			if (abort) begin
				state <= ST_CODE;
				req_cnt <= 5'h00;
				rsp_idx <= 5'h00;
				rsp_len <= 5'h00;
			end else begin
				case (state)
				ST_CODE: begin
					if (push) begin
						req_buf[req_cnt] <= w_data[7:0];
						req_cnt <= req_cnt + 5'h01;
						if (req_cnt == `AUXIO_CODE_LEN - 5'h01) begin
							if (got_code == `AUXIO_CMD_GET) begin
								rsp_code <= got_code;
								rsp_len <= `AUXIO_FRAME_LEN;
								rsp_idx <= 5'h00;
								req_cnt <= 5'h00;
								state <= ST_RSP;
								ev[`AUXIO_EV_ANSWER] <= 1'b1;
							end else if (got_code == `AUXIO_CMD_SET) begin
								rsp_code <= got_code;
								state <= ST_BODY;
							end else begin
								req_cnt <= 5'h00;
								ev[`AUXIO_EV_ERROR] <= 1'b1;
							end
						end
					end
				end
				ST_BODY: begin
					if (push) begin
						req_buf[req_cnt] <= w_data[7:0];
						req_cnt <= req_cnt + 5'h01;
						// spare bytes are taken and dropped
						if (req_cnt == `AUXIO_FRAME_LEN - 5'h01) begin
							aux_config_flags <=
								req_buf[`AUXIO_POS_FLAGS];
							aux_behaviour_byte <=
								req_buf[`AUXIO_POS_BEHAV];
							stored_crc <= {w_data[7:0],
								req_buf[`AUXIO_POS_CRC_LO]};
							rsp_len <= `AUXIO_CODE_LEN;
							rsp_idx <= 5'h00;
							req_cnt <= 5'h00;
							state <= ST_RSP;
							ev[`AUXIO_EV_STORED] <= 1'b1;
							ev[`AUXIO_EV_ANSWER] <= 1'b1;
						end
					end
				end
				ST_RSP: begin
					// a new request before the answer is drained is lost
					if (push)
						ev[`AUXIO_EV_ERROR] <= 1'b1;
					if (pop) begin
						rsp_idx <= rsp_idx + 5'h01;
						if (rsp_idx == rsp_len - 5'h01) begin
							rsp_idx <= 5'h00;
							rsp_len <= 5'h00;
							state <= ST_CODE;
						end
					end
				end
				default: begin
					state <= ST_CODE;
					req_cnt <= 5'h00;
				end
				endcase
			end
		end
	end

	// ----------------------------------------
	// input actions
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			halt_cmd <= 1'b0;
			windings_power_off_cmd <= 1'b0;
			relative_move_cmd <= 1'b0;
			home_cmd <= 1'b0;
			alarm_set_cmd <= 1'b0;
		end else begin
			halt_cmd <= 1'b0;
			windings_power_off_cmd <= 1'b0;
			relative_move_cmd <= 1'b0;
			home_cmd <= 1'b0;
			alarm_set_cmd <= 1'b0;
			if (in_event) begin
				case (aux_behaviour_byte & `AUXIO_IN_MASK)
				`AUXIO_IN_HALT:  halt_cmd <= 1'b1;
				`AUXIO_IN_PWOFF: windings_power_off_cmd <= 1'b1;
				`AUXIO_IN_MOVE:  relative_move_cmd <= 1'b1;
				`AUXIO_IN_HOME:  home_cmd <= 1'b1;
				`AUXIO_IN_ALARM: alarm_set_cmd <= 1'b1;
				default: halt_cmd <= 1'b0;
				endcase
			end
		end
	end

	// ----------------------------------------
	// output behaviour
	// ----------------------------------------
	always @* begin
		case (aux_behaviour_byte & `AUXIO_OUT_MASK)
		`AUXIO_OUT_OFF:     out_active = 1'b0;
		`AUXIO_OUT_ON:      out_active = 1'b1;
		`AUXIO_OUT_MOVING:  out_active = motor_moving;
		`AUXIO_OUT_ALARM:   out_active = alarm_active;
		`AUXIO_OUT_POWERED: out_active = windings_powered;
		`AUXIO_OUT_PRESENT: out_active = motor_present;
		default:            out_active = 1'b0;
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			aux_pin_out <= 1'b0;
			aux_pin_oe  <= 1'b0;
		end else begin
			aux_pin_out <= out_active ^
				aux_config_flags[`AUXIO_FLAG_INVERT];
			aux_pin_oe <= aux_config_flags[`AUXIO_FLAG_OUTPUT];
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			irq_stat <= 4'h0;
			irq_en   <= 4'h0;
			irq      <= 1'b0;
		end else begin
			// a new event wins over a clear in the same cycle
			irq_stat <= (irq_stat & ~clr) | ev;
			if (do_write && w_strb[0] && hit(aw_addr, `AUXIO_REG_IEN))
				irq_en <= w_data[3:0];
			irq <= |(((irq_stat & ~clr) | ev) & irq_en);
		end
	end

endmodule // auxio_pin

`default_nettype wire

/* File: verif/auxio_ext.sv */
`default_nettype none

// ----------------
// equipment on the auxiliary pin
// ----------------
module auxio_ext (
	// level the equipment applies
	input  wire logic drive_lvl,
	// device side of the pin
	input  wire logic pin_out,
	input  wire logic pin_oe,
	// resolved wire
	output var  logic pin_wire
);
	timeunit 1ns;
	timeprecision 1ps;
	// equipment yields the line while the device drives it
	always_comb pin_wire = pin_oe ? pin_out : drive_lvl;
endmodule // auxio_ext

`default_nettype wire

/* File: verif/auxio_pin_sva.sv */
`include "auxio_map.vh"
`default_nettype none

module auxio_pin_sva (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// pin and engine requests
	input wire logic        aux_pin_in,
	input wire logic        aux_pin_oe,
	input wire logic        halt_cmd,
	input wire logic        windings_power_off_cmd,
	input wire logic        relative_move_cmd,
	input wire logic        home_cmd,
	input wire logic        alarm_set_cmd,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire [4:0] cmds;
	assign cmds = {alarm_set_cmd, home_cmd, relative_move_cmd,
		windings_power_off_cmd, halt_cmd};

	a_cmd_onehot: assert property ($onehot0(cmds))
		else $error("two engine requests at once");
	a_cmd_pulse: assert property (cmds != 5'h0 |=> cmds == 5'h0)
		else $error("engine request longer than one cycle");
	// an action needs the pin sampled three clocks earlier to differ from its sample four clocks earlier
	a_event_cause: assert property (cmds != 5'h0 |->
		$past(aux_pin_in, 3) != $past(aux_pin_in, 4))
		else $error("engine request without pin edge");
	a_out_quiet: assert property (
		aux_pin_oe && $past(aux_pin_oe, 6) |-> cmds == 5'h0)
		else $error("action taken in output mode");
	a_b_latency: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_r_latency: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_ready_low: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response open");

	c_halt: cover property (halt_cmd);
	c_alarm: cover property (alarm_set_cmd);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `AUXIO_RESP_SLVERR);
	c_irq: cover property ($rose(irq));
endmodule // auxio_pin_sva

bind auxio_pin auxio_pin_sva chk_u (.clk, .rst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .aux_pin_in, .aux_pin_oe,
	.halt_cmd, .windings_power_off_cmd, .relative_move_cmd, .home_cmd,
	.alarm_set_cmd, .irq);

`default_nettype wire

/* File: verif/aux_io_pin_control_tb.sv */
`include "auxio_map.vh"
`default_nettype none

module aux_io_pin_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------
	// signals and model state
	// ----------------
	logic        clk, rst, ext_lvl, irq, pin_in, pin_out, pin_oe;
	logic [7:0]  awaddr, araddr, m_flags, m_behav;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [3:0]  ms;
	logic [4:0]  cmds;
	logic [15:0] m_crc;
	logic [7:0]  tx[$];
	logic [7:0]  exq[$];
	int          num_errors, compares;

	auxio_pin dut_u (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .aux_pin_in(pin_in), .aux_pin_out(pin_out),
		.aux_pin_oe(pin_oe), .motor_moving(ms[3]), .alarm_active(ms[2]),
		.windings_powered(ms[1]), .motor_present(ms[0]),
		.halt_cmd(cmds[0]), .windings_power_off_cmd(cmds[1]),
		.relative_move_cmd(cmds[2]), .home_cmd(cmds[3]),
		.alarm_set_cmd(cmds[4]), .irq(irq));
	auxio_ext ext_u (.drive_lvl(ext_lvl), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_wire(pin_in));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		repeat (30000) @(posedge clk);
		num_errors++;
		conclude();
	end

	// ----------------
	// tasks
	// ----------------
	task automatic conclude();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] s);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", er, bresp);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
			output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask
	task automatic rdc(input string nm, input logic [7:0] a,
			input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk("rresp", `AUXIO_RESP_OKAY, r);
		chk(nm, e, d);
	endtask
	// a command code opens both the request and its answer
	task automatic put(input logic [31:0] k);
		for (int i = 0; i < 4; i++) begin
			tx.push_back(k[8*i +: 8]);
			exq.push_back(k[8*i +: 8]);
		end
	endtask
	task automatic xfer(input string nm);
		foreach (tx[i])
			wr(`AUXIO_REG_REQ, {24'h0, tx[i]}, `AUXIO_RESP_OKAY);
		tx = {};
		while (exq.size() > 0)
			rdc(nm, `AUXIO_REG_RSP, {24'h0, exq.pop_front()});
	endtask
	task automatic set_cfg(input logic [7:0] f, input logic [7:0] m);
		put(`AUXIO_CMD_SET);
		m_flags = f;
		m_behav = m;
		m_crc = 16'($urandom);
		tx.push_back(f);
		tx.push_back(m);
		repeat (10)
			tx.push_back(8'($urandom));
		tx.push_back(m_crc[7:0]);
		tx.push_back(m_crc[15:8]);
		xfer("set answer");
	endtask
	task automatic get_chk();
		put(`AUXIO_CMD_GET);
		exq.push_back(m_flags);
		exq.push_back(m_behav);
		repeat (10)
			exq.push_back(8'h00);
		exq.push_back(m_crc[7:0]);
		exq.push_back(m_crc[15:8]);
		xfer("get answer");
		rdc("settings", `AUXIO_REG_SET, {16'h0, m_behav, m_flags});
	endtask
	task automatic watch(output logic [4:0] s);
		s = 5'h0;
		repeat (8) begin
			@(posedge clk);
			s = s | cmds;
		end
	endtask
	function automatic logic act(input int o, input logic [3:0] s);
		case (o)
			1: return 1'b1;
			2: return s[3];
			3: return s[2];
			4: return s[1];
			5: return s[0];
			default: return 1'b0;
		endcase
	endfunction
	task automatic irq_chk(input logic e);
		repeat (3) @(posedge clk);
		chk("irq", e, irq);
	endtask

	// ----------------
	// main sequence
	// ----------------
	initial begin
		logic [4:0]  seen;
		logic [31:0] d;
		logic [1:0]  r;
		{rst, ext_lvl, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
		{awaddr, araddr, wdata, ms} = 52'h0;
		void'($urandom(11));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdc("reset settings", `AUXIO_REG_SET, 32'h0);
		chk("reset oe", 1'b0, pin_oe);
		set_cfg(8'h00, 8'($urandom));
		get_chk();
		for (int v = 0; v < 2; v++) begin
			ext_lvl <= v[0];
			for (int a = 0; a < 16; a++) begin
				set_cfg({6'h0, v[0], 1'b0}, {4'($urandom), a[3:0]});
				@(posedge clk);
				ext_lvl <= ~v[0];
				watch(seen);
				chk("action", (a >= 1 && a <= 5) ? 5'h1 << (a - 1) : 5'h0,
					seen);
				rdc("pin", `AUXIO_REG_PIN, {30'h0, 1'b1, ~v[0]});
				ext_lvl <= v[0];
				watch(seen);
				chk("inactive edge", 5'h0, seen);
			end
		end
		for (int v = 0; v < 2; v++)
			for (int o = 0; o < 7; o++) begin
				set_cfg({6'h0, v[0], 1'b1}, {o[3:0], 4'($urandom)});
				repeat (4) begin
					ms <= 4'($urandom);
					repeat (2) @(posedge clk);
					chk("pin oe", 1'b1, pin_oe);
					chk("pin out", v[0] ^ act(o, ms),
						pin_out);
				end
			end
		wr(`AUXIO_REG_ICLR, 32'hf, `AUXIO_RESP_OKAY);
		wr(`AUXIO_REG_IEN, 32'h2, `AUXIO_RESP_OKAY);
		irq_chk(1'b0);
		set_cfg(8'h00, 8'h00);
		irq_chk(1'b1);
		rd(`AUXIO_REG_ISTAT, d, r);
		chk("stored status", 1'b1, d[1]);
		wr(`AUXIO_REG_ICLR, 32'h2, `AUXIO_RESP_OKAY);
		irq_chk(1'b0);
		wr(`AUXIO_REG_IEN, 32'h0, `AUXIO_RESP_OKAY);
		set_cfg(8'h02, 8'h10);
		irq_chk(1'b0);
		wr(`AUXIO_REG_IEN, 32'h2, `AUXIO_RESP_OKAY);
		irq_chk(1'b1);
		wr(`AUXIO_REG_ICLR, 32'hf, `AUXIO_RESP_OKAY);
		put(32'h1234_5678);
		exq = {};
		xfer("unknown code");
		rd(`AUXIO_REG_ISTAT, d, r);
		chk("frame error", 1'b1, d[2]);
		wr(`AUXIO_REG_REQ, 32'h73, `AUXIO_RESP_OKAY);
		wr(`AUXIO_REG_FRAME, 32'h1, `AUXIO_RESP_OKAY);
		rdc("frame idle", `AUXIO_REG_FRAME, 32'h0);
		rd(8'h40, d, r);
		chk("unmapped rresp", `AUXIO_RESP_SLVERR, r);
		wr(`AUXIO_REG_SET, 32'h0, `AUXIO_RESP_SLVERR);
		get_chk();
		conclude();
	end
endmodule // aux_io_pin_control_tb

`default_nettype wire
